// file: inc/pwt_pkg.sv
// Constants, register map, field layouts and types for the telemetry and calibration block.
// Assumes one 50 MHz clock, a synchronous reset and an AHB-Lite master with 32-bit single word transfers.
package pwt_pkg;

	// Sizes
	localparam int NUM_PHASES = 7;
	localparam int NUM_CHANNELS = 2;
	localparam int CODE_W = 12;

	// Register byte offsets
	localparam logic [7:0] ADDR_PAGE = 8'h00;
	localparam logic [7:0] ADDR_PHASE = 8'h04;
	localparam logic [7:0] ADDR_IOUT_GAIN = 8'h08;
	localparam logic [7:0] ADDR_IOUT_OFFSET = 8'h0C;
	localparam logic [7:0] ADDR_VOUT_SCALE = 8'h10;
	localparam logic [7:0] ADDR_IIN_CAL = 8'h14;
	localparam logic [7:0] ADDR_PHASE_MAP = 8'h18;
	localparam logic [7:0] ADDR_READ_VOUT = 8'h20;
	localparam logic [7:0] ADDR_READ_IOUT = 8'h24;
	localparam logic [7:0] ADDR_READ_POUT = 8'h28;
	localparam logic [7:0] ADDR_READ_TEMP = 8'h2C;
	localparam logic [7:0] ADDR_READ_VIN = 8'h30;
	localparam logic [7:0] ADDR_READ_IIN = 8'h34;
	localparam logic [7:0] ADDR_READ_PIN = 8'h38;
	localparam logic [7:0] ADDR_STATUS = 8'h3C;

	// Field positions of the input current calibration word
	localparam int IIN_FE_LSB = 0;
	localparam int IIN_DIG_LSB = 8;
	localparam int INPUT_CURRENT_OFFSET_LSB = 16;
	// Field positions of the phase map word
	localparam int MAP_EN_LSB = 0;
	localparam int MAP_CH_LSB = 8;

	// Reset values
	localparam logic [15:0] GAIN_RESET = 16'h0100;
	localparam logic [7:0] FE_GAIN_RESET = 8'h01;
	localparam logic [7:0] DIG_GAIN_RESET = 8'h02;
	localparam logic [6:0] PHASE_EN_RESET = 7'h7F;
	localparam logic [6:0] PHASE_CH_RESET = 7'h00;
	localparam logic [7:0] PHASE_TOTAL = 8'hFF;

	// Fixed-point scaling: currents in 1/16 A, voltages in mV
	localparam int GAIN_FRAC_BITS = 8;
	localparam logic signed [15:0] PHASE_I_MIN = -16'sd160;
	localparam logic signed [15:0] PHASE_I_MAX = 16'sd1120;
	localparam logic [15:0] VOUT_MAX_UNITY = 16'd3740;
	localparam logic [15:0] VOUT_MAX_HALF = 16'd5500;
	// Input current divisor: 100 (10 uV codes to mV) * 2 (half LSB) * 800 mV / 16
	localparam logic [15:0] IIN_FULL_SCALE_MV = 16'd800;
	localparam logic [15:0] IIN_DIVISOR = 16'd10000;

	// Serial divider length
	localparam logic [5:0] DIV_STEPS = 6'd32;

	// Engine states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_PH_GO = 5'b00010,
		ST_PH_WAIT = 5'b00100,
		ST_IIN_WAIT = 5'b01000,
		ST_SUM = 5'b10000
	} pwt_state_type;

endpackage : pwt_pkg

// file: hdl/pwt_divider.sv
// Serial restoring divider, one quotient bit per clock.
// Assumes operands stay stable only at the start pulse; they are captured then.
`timescale 1ns/10ps
module pwt_divider (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Request
	input wire logic start,
	input wire logic [31:0] dividend,
	input wire logic [15:0] divisor,
	// Answer
	output logic done,
	output logic [31:0] quotient
);
	import pwt_pkg::*;

	typedef struct packed {
		logic busy;
		logic done;
		logic [5:0] cnt;
		logic [16:0] rem;
		logic [31:0] quo;
		logic [15:0] den;
	} pwt_div_type;

	pwt_div_type div_q, div_d;
	logic [16:0] trial;

	// One shift-subtract step per cycle
	always_comb begin
		div_d = div_q;
		div_d.done = 1'b0;
		trial = {div_q.rem[15:0], div_q.quo[31]};
		if (start && !div_q.busy) begin
			div_d.busy = 1'b1;
			div_d.cnt = DIV_STEPS;
			div_d.rem = 17'h00000;
			div_d.quo = dividend;
			div_d.den = divisor;
		end else if (div_q.busy) begin
			if (trial >= {1'b0, div_q.den}) begin
				div_d.rem = trial - {1'b0, div_q.den};
				div_d.quo = {div_q.quo[30:0], 1'b1};
			end else begin
				div_d.rem = trial;
				div_d.quo = {div_q.quo[30:0], 1'b0};
			end
			div_d.cnt = div_q.cnt - 6'd1;
			if (div_q.cnt == 6'd1) begin
				div_d.busy = 1'b0;
				div_d.done = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	assign done = div_q.done;
	assign quotient = div_q.quo;

endmodule : pwt_divider

// file: hdl/pwt_telemetry.sv
// Telemetry and calibration datapath with an AHB-Lite register slave.
// Assumes ADC codes come from logic on the same clock and hold while the sample strobe pulses.
`timescale 1ns/10ps
module pwt_telemetry (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Converter results
	input wire logic adc_sample_strobe,
	input wire logic [pwt_pkg::NUM_PHASES-1:0][pwt_pkg::CODE_W-1:0] phase_current_sense_input,
	input wire logic [pwt_pkg::CODE_W-1:0] ref_code,
	input wire logic [pwt_pkg::CODE_W-1:0] remote_sense_diff_a,
	input wire logic [pwt_pkg::CODE_W-1:0] remote_sense_diff_b,
	input wire logic [15:0] channel_a_temp_sense,
	input wire logic [15:0] channel_b_temp_sense,
	input wire logic [15:0] input_voltage_shunt_neg,
	input wire logic [15:0] input_shunt_positive,
	// Status
	output logic telemetry_update
);
	import pwt_pkg::*;

	typedef struct packed {
		logic hready_out;
		logic resp;
		logic [31:0] rdata;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic page;
		logic [7:0] phase;
		logic [1:0][15:0] gain;
		logic [NUM_PHASES-1:0][15:0] ofs;
		logic [1:0] vhalf;
		logic [7:0] fe_gain;
		logic [7:0] dig_gain;
		logic [15:0] input_current_offset;
		logic [NUM_PHASES-1:0] ph_en;
		logic [NUM_PHASES-1:0] ph_ch;
		pwt_state_type state;
		logic [2:0] idx;
		logic neg;
		logic div_go;
		logic [NUM_PHASES-1:0][CODE_W-1:0] csp;
		logic [CODE_W-1:0] vref;
		logic [1:0][CODE_W-1:0] vcode;
		logic [15:0] shunt;
		logic [NUM_PHASES-1:0][15:0] ph_val;
		logic [1:0][15:0] iout;
		logic [1:0][15:0] vout;
		logic [1:0][15:0] temp;
		logic [1:0][31:0] pout;
		logic [15:0] vin;
		logic [15:0] iin;
		logic [31:0] pin;
		logic [7:0] upd_cnt;
		logic update;
	} pwt_state_rec_type;

	pwt_state_rec_type st_q, st_d;

	logic div_done;
	logic [31:0] div_quo;
	logic [31:0] div_num;
	logic [15:0] div_den;

	// Shared divider for phase currents and input current
	pwt_divider pwt_divider_inst (
		.clock(clock),
		.sys_rst(sys_rst),
		.start(st_q.div_go),
		.dividend(div_num),
		.divisor(div_den),
		.done(div_done),
		.quotient(div_quo)
	);

	// Saturate a wide signed value to 16 bits
	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sd32767) begin
			sat16 = 16'h7FFF;
		end else if (v < -32'sd32768) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	logic signed [12:0] diff;
	logic [12:0] mag;
	logic [15:0] gain_sel;
	logic [31:0] iin_prod;
	logic [31:0] q_sat;
	logic signed [31:0] ph_sum;
	logic [1:0][31:0] tot;
	logic [15:0] vscaled;
	logic [15:0] vlimit;
	logic [7:0] ph_count;
	logic [15:0] ph_read;
	logic ph_found;
	logic [31:0] rd_word;
	logic wr_hit;
	logic rd_hit;

	// Operand selection for the divider
	always_comb begin
		diff = $signed({1'b0, st_q.csp[st_q.idx]}) - $signed({1'b0, st_q.vref});
		mag = diff[12] ? 13'(-diff) : 13'(diff);
		gain_sel = st_q.gain[st_q.ph_ch[st_q.idx]];
		iin_prod = 32'(st_q.shunt * st_q.fe_gain * st_q.dig_gain);
		if (st_q.state == ST_IIN_WAIT) begin
			// shunt times both gains over full scale
			div_num = iin_prod;
			div_den = IIN_DIVISOR;
		end else begin
			div_num = {11'h000, mag, 8'h00};
			div_den = (gain_sel == 16'h0000) ? 16'h0001 : gain_sel;
		end
		q_sat = (div_quo > 32'd32767) ? 32'd32767 : div_quo;
	end

	// Channel totals over active phases
	always_comb begin
		tot = '0;
		for (int c = 0; c < NUM_CHANNELS; c++) begin
			for (int i = 0; i < NUM_PHASES; i++) begin
				if (st_q.ph_en[i] && (st_q.ph_ch[i] == c[0])) begin
					tot[c] = 32'($signed(tot[c]) + $signed({{16{st_q.ph_val[i][15]}}, st_q.ph_val[i]}));
				end
			end
		end
	end

	// Per-phase readback for the selected page and phase index
	always_comb begin
		ph_count = 8'h00;
		ph_read = 16'h0000;
		ph_found = 1'b0;
		for (int i = 0; i < NUM_PHASES; i++) begin
			if (st_q.ph_en[i] && (st_q.ph_ch[i] == st_q.page)) begin
				if (ph_count == st_q.phase) begin
					ph_read = st_q.ph_val[i];
					ph_found = 1'b1;
				end
				ph_count = ph_count + 8'h01;
			end
		end
		if ($signed(ph_read) < PHASE_I_MIN) begin
			ph_read = PHASE_I_MIN;
		end else if ($signed(ph_read) > PHASE_I_MAX) begin
			ph_read = PHASE_I_MAX;
		end
		if (!ph_found) begin
			ph_read = 16'h0000;
		end
	end

	// Read data decode, paged where the value belongs to a channel
	always_comb begin
		wr_hit = hsel && hready && htrans[1] && hwrite;
		rd_hit = hsel && hready && htrans[1] && !hwrite;
		rd_word = 32'h00000000;
		if (haddr[7:0] == ADDR_PAGE) begin
			rd_word = {31'h00000000, st_q.page};
		end else if (haddr[7:0] == ADDR_PHASE) begin
			rd_word = {24'h000000, st_q.phase};
		end else if (haddr[7:0] == ADDR_IOUT_GAIN) begin
			rd_word = {16'h0000, st_q.gain[st_q.page]};
		end else if (haddr[7:0] == ADDR_IOUT_OFFSET) begin
			rd_word = {16'h0000, ph_found ? st_q.ofs[st_q.phase[2:0]] : 16'h0000};
		end else if (haddr[7:0] == ADDR_VOUT_SCALE) begin
			rd_word = {31'h00000000, st_q.vhalf[st_q.page]};
		end else if (haddr[7:0] == ADDR_IIN_CAL) begin
			rd_word = {st_q.input_current_offset, st_q.dig_gain, st_q.fe_gain};
		end else if (haddr[7:0] == ADDR_PHASE_MAP) begin
			rd_word = {17'h00000, st_q.ph_ch, 1'b0, st_q.ph_en};
		end else if (haddr[7:0] == ADDR_READ_VOUT) begin
			rd_word = {16'h0000, st_q.vout[st_q.page]};
		end else if (haddr[7:0] == ADDR_READ_IOUT) begin
			rd_word = {16'h0000, (st_q.phase == PHASE_TOTAL) ? st_q.iout[st_q.page] : ph_read};
		end else if (haddr[7:0] == ADDR_READ_POUT) begin
			rd_word = st_q.pout[st_q.page];
		end else if (haddr[7:0] == ADDR_READ_TEMP) begin
			rd_word = {16'h0000, st_q.temp[st_q.page]};
		end else if (haddr[7:0] == ADDR_READ_VIN) begin
			rd_word = {16'h0000, st_q.vin};
		end else if (haddr[7:0] == ADDR_READ_IIN) begin
			rd_word = {16'h0000, st_q.iin};
		end else if (haddr[7:0] == ADDR_READ_PIN) begin
			rd_word = st_q.pin;
		end else if (haddr[7:0] == ADDR_STATUS) begin
			rd_word = {23'h000000, st_q.state != ST_IDLE, st_q.upd_cnt};
		end
	end

	// Next state: bus, calibration registers and compute engine
	always_comb begin
		st_d = st_q;
		st_d.hready_out = 1'b1;
		st_d.resp = 1'b0;
		st_d.div_go = 1'b0;
		st_d.update = 1'b0;
		vscaled = 16'h0000;
		vlimit = 16'h0000;
		ph_sum = 32'sd0;
		// Read data is captured in the address phase
		if (rd_hit) begin
			st_d.rdata = rd_word;
		end
		st_d.wr_pend = wr_hit;
		if (wr_hit) begin
			st_d.wr_addr = haddr[7:0];
		end
		// Data phase of a write
		if (st_q.wr_pend) begin
			if (st_q.wr_addr == ADDR_PAGE) begin
				st_d.page = hwdata[0];
			end else if (st_q.wr_addr == ADDR_PHASE) begin
				st_d.phase = hwdata[7:0];
			end else if (st_q.wr_addr == ADDR_IOUT_GAIN) begin
				// one gain for the whole channel
				st_d.gain[st_q.page] = hwdata[15:0];
			end else if (st_q.wr_addr == ADDR_IOUT_OFFSET) begin
				for (int i = 0; i < NUM_PHASES; i++) begin
					if (ph_found && (st_q.phase[2:0] == i[2:0])) begin
						st_d.ofs[i] = hwdata[15:0];
					end
				end
			end else if (st_q.wr_addr == ADDR_VOUT_SCALE) begin
				st_d.vhalf[st_q.page] = hwdata[0];
			end else if (st_q.wr_addr == ADDR_IIN_CAL) begin
				st_d.fe_gain = hwdata[IIN_FE_LSB +: 8];
				st_d.dig_gain = hwdata[IIN_DIG_LSB +: 8];
				st_d.input_current_offset = hwdata[INPUT_CURRENT_OFFSET_LSB +: 16];
			end else if (st_q.wr_addr == ADDR_PHASE_MAP) begin
				st_d.ph_en = hwdata[MAP_EN_LSB +: NUM_PHASES];
				st_d.ph_ch = hwdata[MAP_CH_LSB +: NUM_PHASES];
			end
		end
		// Compute engine
		case (st_q.state)
			ST_IDLE: begin
				if (adc_sample_strobe) begin
					st_d.csp = phase_current_sense_input;
					st_d.vref = ref_code;
					st_d.vcode[0] = remote_sense_diff_a;
					st_d.vcode[1] = remote_sense_diff_b;
					st_d.shunt = input_shunt_positive;
					st_d.temp[0] = channel_a_temp_sense;
					st_d.temp[1] = channel_b_temp_sense;
					st_d.vin = input_voltage_shunt_neg;
					st_d.idx = 3'd0;
					st_d.state = ST_PH_GO;
				end
			end
			ST_PH_GO: begin
				st_d.neg = diff[12];
				st_d.div_go = 1'b1;
				st_d.state = ST_PH_WAIT;
			end
			ST_PH_WAIT: begin
				if (div_done) begin
					ph_sum = (st_q.neg ? -$signed(q_sat) : $signed(q_sat)) + $signed({{16{st_q.ofs[st_q.idx][15]}},
						st_q.ofs[st_q.idx]});
					st_d.ph_val[st_q.idx] = sat16(ph_sum);
					if (st_q.idx == 3'(NUM_PHASES - 1)) begin
						st_d.div_go = 1'b1;
						st_d.state = ST_IIN_WAIT;
					end else begin
						st_d.idx = st_q.idx + 3'd1;
						st_d.state = ST_PH_GO;
					end
				end
			end
			ST_IIN_WAIT: begin
				if (div_done) begin
					// half step held in the divisor
					ph_sum = $signed(q_sat) + $signed({{16{st_q.input_current_offset[15]}}, st_q.input_current_offset});
					st_d.iin = sat16(ph_sum);
					st_d.state = ST_SUM;
				end
			end
			ST_SUM: begin
				for (int c = 0; c < NUM_CHANNELS; c++) begin
					vscaled = st_q.vhalf[c] ? {3'b000, st_q.vcode[c], 1'b0} : {4'h0, st_q.vcode[c]};
					vlimit = st_q.vhalf[c] ? VOUT_MAX_HALF : VOUT_MAX_UNITY;
					st_d.vout[c] = (vscaled > vlimit) ? vlimit : vscaled;
					st_d.iout[c] = sat16($signed(tot[c]));
				end
				st_d.upd_cnt = st_q.upd_cnt + 8'h01;
				st_d.update = 1'b1;
				st_d.state = ST_IDLE;
			end
			default: begin
				st_d.state = ST_IDLE;
			end
		endcase
		if (st_q.update) begin
			for (int c = 0; c < NUM_CHANNELS; c++) begin
				st_d.pout[c] = 32'($signed({1'b0, st_q.vout[c]}) * $signed(st_q.iout[c]));
			end
			st_d.pin = 32'($signed({1'b0, st_q.vin}) * $signed(st_q.iin));
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_q <= '0;
			st_q.state <= ST_IDLE;
			st_q.gain <= {GAIN_RESET, GAIN_RESET};
			st_q.fe_gain <= FE_GAIN_RESET;
			st_q.dig_gain <= DIG_GAIN_RESET;
			st_q.ph_en <= PHASE_EN_RESET;
			st_q.ph_ch <= PHASE_CH_RESET;
			st_q.phase <= PHASE_TOTAL;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops
	assign hreadyout = st_q.hready_out;
	assign hresp = st_q.resp;
	assign hrdata = st_q.rdata;
	assign telemetry_update = st_q.update;

endmodule : pwt_telemetry

// file: testbench/pwt_adc_model.sv
// Converter model: sense codes around a fixed reference plus a strobe.
// Assumes the bench requests samples only while the engine is idle.
`timescale 1ns/10ps
module pwt_adc_model
	import pwt_pkg::*;
#(
	parameter logic [CODE_W-1:0] REF_LEVEL = 12'h3E8
)(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Request from the bench
	input wire logic fire,
	input wire logic [NUM_PHASES-1:0][15:0] diff,
	// Converter results
	output logic adc_sample_strobe,
	output logic [NUM_PHASES-1:0][CODE_W-1:0] phase_current_sense_input,
	output logic [CODE_W-1:0] ref_code
);
	assign ref_code = REF_LEVEL;
	// Codes settle together with the one-cycle strobe
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			adc_sample_strobe <= 1'b0;
			phase_current_sense_input <= {NUM_PHASES{REF_LEVEL}};
		end else begin
			adc_sample_strobe <= fire;
			for (int i = 0; i < NUM_PHASES; i++) begin
				if (fire) begin
					phase_current_sense_input[i] <= REF_LEVEL + diff[i][CODE_W-1:0];
				end
			end
		end
	end
endmodule : pwt_adc_model

// file: testbench/pwt_telemetry_assertions.sv
// Concurrent checks on the bus and status ports of the telemetry block.
// Assumes one clock domain and converter inputs held between samples.
`timescale 1ns/10ps
module pwt_telemetry_assertions
	import pwt_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Converter and status
	input wire logic adc_sample_strobe,
	input wire logic [15:0] channel_a_temp_sense,
	input wire logic [15:0] channel_b_temp_sense,
	input wire logic [15:0] input_voltage_shunt_neg,
	input wire logic telemetry_update
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic take_rd;
	logic wp_q;
	logic [7:0] wa_q;
	logic pg_q;
	logic [7:0] ph_q;
	// Read taken in address phase
	assign take_rd = hsel && hready && htrans[1] && !hwrite;
	// Shadow of page and phase selection
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wp_q <= 1'b0;
			wa_q <= 8'h00;
			pg_q <= 1'b0;
			ph_q <= PHASE_TOTAL;
		end else begin
			wp_q <= hsel && hready && htrans[1] && hwrite;
			wa_q <= haddr[7:0];
			if (wp_q && wa_q == ADDR_PAGE) pg_q <= hwdata[0];
			if (wp_q && wa_q == ADDR_PHASE) ph_q <= hwdata[7:0];
		end
	end
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bus response not OKAY");
	property p_ready; !$past(sys_rst) |-> hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("wait state inserted");
	property p_vout_span; take_rd && haddr[7:0] == ADDR_READ_VOUT |=> hrdata <= {16'h0, VOUT_MAX_HALF}; endproperty
	a_vout_span: assert property (p_vout_span) else $error("voltage beyond span");
	property p_phase_range;
		take_rd && haddr[7:0] == ADDR_READ_IOUT && ph_q != PHASE_TOTAL
		|=> $signed(hrdata[15:0]) >= PHASE_I_MIN && $signed(hrdata[15:0]) <= PHASE_I_MAX;
	endproperty
	a_phase_range: assert property (p_phase_range) else $error("phase current out of range");
	property p_temp;
		take_rd && haddr[7:0] == ADDR_READ_TEMP |=> hrdata[15:0] == (pg_q ? channel_b_temp_sense : channel_a_temp_sense);
	endproperty
	a_temp: assert property (p_temp) else $error("temperature altered");
	property p_vin; take_rd && haddr[7:0] == ADDR_READ_VIN |=> hrdata[15:0] == input_voltage_shunt_neg; endproperty
	a_vin: assert property (p_vin) else $error("input voltage altered");
	property p_update; adc_sample_strobe |-> ##[1:400] telemetry_update; endproperty
	a_update: assert property (p_update) else $error("no update after sample");
	property p_pulse; telemetry_update |=> !telemetry_update; endproperty
	a_pulse: assert property (p_pulse) else $error("update pulse too long");
endmodule : pwt_telemetry_assertions
bind pwt_telemetry pwt_telemetry_assertions pwt_telemetry_assertions_inst (.clock, .sys_rst, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .adc_sample_strobe,
	.channel_a_temp_sense, .channel_b_temp_sense, .input_voltage_shunt_neg, .telemetry_update);

// file: testbench/tb_power_telemetry_calibration.sv
// Self-checking bench for the telemetry block over AHB-Lite.
// Assumes zero-wait slave, one clock and the converter model beside it.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_power_telemetry_calibration
	import pwt_pkg::*;
;
	localparam logic [31:0] M16 = 32'h0000FFFF;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp, fire, telemetry_update, adc_sample_strobe;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [NUM_PHASES-1:0][CODE_W-1:0] phase_current_sense_input;
	logic [NUM_PHASES-1:0][15:0] diff;
	logic [CODE_W-1:0] ref_code, remote_sense_diff_a, remote_sense_diff_b;
	logic [15:0] channel_a_temp_sense, channel_b_temp_sense, input_voltage_shunt_neg, input_shunt_positive;
	int n_fail, checked;
	assign hready = hreadyout;
	pwt_telemetry pwt_telemetry_inst (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .adc_sample_strobe, .phase_current_sense_input, .ref_code, .remote_sense_diff_a,
		.remote_sense_diff_b, .channel_a_temp_sense, .channel_b_temp_sense, .input_voltage_shunt_neg,
		.input_shunt_positive, .telemetry_update);
	pwt_adc_model pwt_adc_model_inst (.clock, .sys_rst, .fire, .diff, .adc_sample_strobe, .phase_current_sense_input,
		.ref_code);
	// Verdict and end of run
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	// Bounded wait on ready (0) or update pulse (1)
	task automatic edge_wait(input int which);
		int n;
		n = 0;
		do begin @(posedge clock); n++; end while ((which ? telemetry_update : hreadyout) !== 1'b1 && n < 1000);
		if (n >= 1000) begin n_fail++; $display("[ERR] %0t wait ran out", $time); complete_run(); end
	endtask : edge_wait
	// One single-word transfer, idle cycle after a write
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
		edge_wait(0);
		htrans <= 2'h0; hwdata <= wd;
		edge_wait(0);
		rd = hrdata;
		if (wr) @(posedge clock);
	endtask : bus
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, 32'h0);
		`CHK(rd & m, e)
	endtask : chk_rd
	// Request a sample and wait for the computation set
	task automatic sample();
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		edge_wait(1);
		repeat (2) @(posedge clock);
	endtask : sample
	task automatic t_reset();
		chk_rd(ADDR_PHASE, 32'h000000FF, ALL);
		chk_rd(ADDR_IOUT_GAIN, {16'h0, GAIN_RESET}, ALL);
		chk_rd(ADDR_PHASE_MAP, 32'h0000007F, ALL);
		chk_rd(ADDR_IIN_CAL, 32'h00000201, ALL);
		chk_rd(8'h40, 32'h0, ALL);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_phase();
		bus(1'b1, ADDR_PHASE, 32'h0);
		bus(1'b1, ADDR_IOUT_OFFSET, 32'h10);
		chk_rd(ADDR_IOUT_OFFSET, 32'h10, ALL);
		sample();
		chk_rd(ADDR_READ_IOUT, 32'h60, M16);
		bus(1'b1, ADDR_PHASE, 32'h1);
		chk_rd(ADDR_READ_IOUT, 32'h50, M16);
		bus(1'b1, ADDR_PHASE, 32'hFF);
		chk_rd(ADDR_READ_IOUT, 32'h240, M16);
		bus(1'b1, ADDR_IOUT_GAIN, 32'h200);
		sample();
		chk_rd(ADDR_READ_IOUT, 32'h128, M16);
		bus(1'b1, ADDR_PHASE, 32'h1);
		chk_rd(ADDR_READ_IOUT, 32'h28, M16);
		$display("t_phase done");
	endtask : t_phase
	task automatic t_clamp();
		bus(1'b1, ADDR_IOUT_GAIN, 32'h100);
		diff[1] <= 16'h07D0;
		diff[2] <= 16'hFE70;
		sample();
		chk_rd(ADDR_READ_IOUT, 32'h460, M16);
		bus(1'b1, ADDR_PHASE, 32'h2);
		chk_rd(ADDR_READ_IOUT, 32'hFF60, M16);
		diff <= {NUM_PHASES{16'h0050}};
		$display("t_clamp done");
	endtask : t_clamp
	task automatic t_volt();
		bus(1'b1, ADDR_PHASE, 32'hFF);
		sample();
		chk_rd(ADDR_READ_VOUT, 32'h4B0, ALL);
		chk_rd(ADDR_READ_POUT, 32'h000A8C00, ALL);
		bus(1'b1, ADDR_VOUT_SCALE, 32'h1);
		remote_sense_diff_a <= 12'h7D0;
		sample();
		chk_rd(ADDR_READ_VOUT, 32'hFA0, ALL);
		remote_sense_diff_a <= 12'hBB8;
		sample();
		chk_rd(ADDR_READ_VOUT, 32'h157C, ALL);
		bus(1'b1, ADDR_VOUT_SCALE, 32'h0);
		remote_sense_diff_a <= 12'hFA0;
		sample();
		chk_rd(ADDR_READ_VOUT, 32'hE9C, ALL);
		$display("t_volt done");
	endtask : t_volt
	task automatic t_input();
		// front-end gain keeps shunt signal under full scale
		bus(1'b1, ADDR_IIN_CAL, 32'h00100408);
		sample();
		chk_rd(ADDR_READ_IIN, 32'h29, M16);
		chk_rd(ADDR_READ_PIN, 32'h000781E0, ALL);
		chk_rd(ADDR_READ_TEMP, 32'h1234, M16);
		$display("t_input done");
	endtask : t_input
	task automatic t_page();
		bus(1'b1, ADDR_PAGE, 32'h1);
		sample();
		chk_rd(ADDR_READ_VOUT, 32'h3E8, ALL);
		chk_rd(ADDR_READ_TEMP, 32'hABC, M16);
		chk_rd(ADDR_READ_VIN, 32'h2EE0, M16);
		chk_rd(ADDR_READ_IIN, 32'h29, M16);
		chk_rd(ADDR_READ_IOUT, 32'h0, M16);
		chk_rd(ADDR_STATUS, 32'h00000009, ALL);
		$display("t_page done");
	endtask : t_page
	// Clock source
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Main sequence
	initial begin
		sys_rst = 1'b1; hsel = 1'b1; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
		fire = 1'b0; diff = {NUM_PHASES{16'h0050}}; remote_sense_diff_a = 12'h4B0; remote_sense_diff_b = 12'h3E8;
		channel_a_temp_sense = 16'h1234; channel_b_temp_sense = 16'h0ABC;
		input_voltage_shunt_neg = 16'h2EE0; input_shunt_positive = 16'h1F40;
		n_fail = 0; checked = 0;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		t_reset();
		t_phase();
		t_clamp();
		t_volt();
		t_input();
		t_page();
		complete_run();
	end
endmodule : tb_power_telemetry_calibration
